// *** verilog/fpd_pkg.sv ***
// front panel message display: shared constants and types
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus
package fpd_pkg;
    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int SCROLL_STEP_NS = 500_000_000;  // two chars per second
    localparam int TICK_CYCLES    = SCROLL_STEP_NS / CLK_PERIOD_NS;

    // ========================================================
    // text store and panel geometry
    localparam int TEXT_MAX   = 80;
    localparam int PANEL_CHRS = 10;
    localparam int VIS_CHRS   = PANEL_CHRS - 1;  // last place is the clock
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_QUOTE = 8'h22;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CHAR   = 8'h08;
    localparam logic [7:0] OFS_LEN    = 8'h0C;
    localparam logic [7:0] OFS_CLEAR  = 8'h10;
    localparam logic [7:0] OFS_QUERY  = 8'h14;
    localparam logic CTRL_RESET = 1'b1;          // display on after reset
    localparam int QRY_VALID_BIT = 8;

    // ========================================================
    // fault vector layout
    localparam int N_RAIL = 7;
    localparam int N_FAN  = 3;
    localparam int N_SLOT = 12;
    localparam int N_ACK  = 7;
    localparam int F_OV   = 0;
    localparam int F_UV   = F_OV + N_RAIL;
    localparam int F_FAN  = F_UV + N_RAIL;
    localparam int F_AMB  = F_FAN + N_FAN;
    localparam int F_SLOT = F_AMB + 1;
    localparam int F_ACK  = F_SLOT + N_SLOT;
    localparam int F_BERR = F_ACK + N_ACK;
    localparam int F_SYSF = F_BERR + 1;
    localparam int F_ACF  = F_SYSF + 1;
    localparam int F_SESS = F_ACF + 1;
    localparam int F_TOT  = F_SESS + 1;
    localparam int F_FILT = F_TOT + 1;
    localparam int N_FAULT = F_FILT + 1;

    // message shown on the panel
    typedef enum logic [4:0] {
        MK_OFF, MK_BLANK, MK_TEXT, MK_SYS_OK, MK_STANDBY,
        MK_RAIL_OV, MK_RAIL_UV, MK_FAN, MK_AMBIENT, MK_SLOT,
        MK_ACK_LINE, MK_BUS_ERROR, MK_SYSFAIL, MK_ACFAIL,
        MK_SESSION, MK_TOTAL, MK_FILTER
    } fpd_kind_t;

    // text query reply sequencer
    typedef enum logic [2:0] {
        Q_OPEN, Q_BODY, Q_DUP, Q_DONE
    } fpd_qstate_t;
endpackage

// *** verilog/fpd_display.sv ***
// front panel message display controller
// assumes fault levels and mains switch arrive asynchronously from
// the monitor; a character ROM outside turns kind/arg into glyphs
`timescale 1ns/1ns
// Summary of operation
// - display is on after power-up and every reset
// - display off shows no faults nor text; on restores normal showing
// - display state reads 0 when off, 1 when on
// - user text of zero to eighty characters is accepted and stored
// - rightmost place keeps status clock; nine text characters visible
// - text longer than nine scrolls one character per half second
// - text query returns string in double quotes, inner quotes doubled
// - zero-length text shows blank panel unless a fault is present
// - clear makes text undefined; idle or fault messages return
// - priority: fault, then defined text, then System OK or Standby
// - every fault message is shown flashing
// - several faults are shown one after another round-robin
// - each of seven rails has over- and under-voltage messages
// - fan speed message carries fan one to three; ambient heat message
// - slot temperature-rise message carries slot one to twelve
// - ack line count, bus error count, sysfail and acfail messages
// - session uptime, total uptime and filter service messages
module fpd_display
    import fpd_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
)(
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // avalon-mm slave
    input  wire logic [7:0]           i_address,
    input  wire logic                 i_read,
    input  wire logic                 i_write,
    input  wire logic [31:0]          i_writedata,
    output logic      [31:0]          o_readdata,
    output logic                      o_waitrequest,
    // monitor inputs, asynchronous
    input  wire logic                 i_mains_on,
    input  wire logic [N_RAIL-1:0]    i_rail_ov,
    input  wire logic [N_RAIL-1:0]    i_rail_uv,
    input  wire logic [N_FAN-1:0]     i_fan_fault,
    input  wire logic                 i_ambient_heat_fault,
    input  wire logic [N_SLOT-1:0]    i_slot_fault,
    input  wire logic [N_ACK-1:0]     i_ack_line_count_fault,
    input  wire logic                 i_bus_error_count_fault,
    input  wire logic                 i_sysfail,
    input  wire logic                 i_acfail,
    input  wire logic                 i_session_uptime_fault,
    input  wire logic                 i_total_uptime_fault,
    input  wire logic                 i_filter_fault,
    // panel
    output fpd_kind_t                 o_msg_kind,
    output logic      [3:0]           o_msg_arg,
    output logic                      o_blank,
    output logic      [8*VIS_CHRS-1:0] o_text
);
    // ========================================================
    // input synchronisers
    logic [N_FAULT:0] sync1_reg, sync2_reg;
    logic [N_FAULT-1:0] faults;
    logic             mains;
    // first stage is read only by the second
    always_ff @(posedge i_clk)
    begin
        sync1_reg <= {i_mains_on, i_filter_fault, i_total_uptime_fault,
                      i_session_uptime_fault, i_acfail, i_sysfail,
                      i_bus_error_count_fault, i_ack_line_count_fault,
                      i_slot_fault, i_ambient_heat_fault, i_fan_fault,
                      i_rail_uv, i_rail_ov};
        sync2_reg <= sync1_reg;
    end
    assign faults = sync2_reg[N_FAULT-1:0];
    assign mains  = sync2_reg[N_FAULT];

    // ========================================================
    // bus handshake: one wait cycle, then accept
    logic ack_reg, acc, rd_acc, wr_acc;
    assign o_waitrequest = (i_read | i_write) & ~ack_reg;
    assign acc    = (i_read | i_write) & ack_reg;
    assign rd_acc = i_read & ack_reg;
    assign wr_acc = i_write & ack_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_rst) ack_reg <= 1'b0;
        else       ack_reg <= (i_read | i_write) & ~ack_reg;
    end

    // ========================================================
    // display state
    logic disp_on_reg;
    // on at reset; on/off by command
    always_ff @(posedge i_clk)
    begin
        if (i_rst) disp_on_reg <= CTRL_RESET;
        else if (wr_acc && i_address == OFS_CTRL)
            disp_on_reg <= i_writedata[0];
    end

    // ========================================================
    // text store
    logic [7:0] text_mem [TEXT_MAX];
    logic [6:0] len_reg;
    logic       defined_reg;
    logic [6:0] eff_len;
    assign eff_len = defined_reg ? len_reg : 7'h00;
    // characters written by index; out-of-range index dropped
    always_ff @(posedge i_clk)
    begin
        if (wr_acc && i_address == OFS_CHAR &&
            i_writedata[14:8] < 7'(TEXT_MAX))
            text_mem[i_writedata[14:8]] <= i_writedata[7:0];
    end
    // length commit defines text; clear undefines it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            len_reg     <= 7'h00;
            defined_reg <= 1'b0;
        end
        else if (wr_acc && i_address == OFS_LEN &&
                 i_writedata[31:0] <= 32'(TEXT_MAX))
        begin
            len_reg     <= i_writedata[6:0];
            defined_reg <= 1'b1;
        end
        else if (wr_acc && i_address == OFS_CLEAR)
            defined_reg <= 1'b0;
    end

    // ========================================================
    // shared half-second timer
    logic [31:0] tmr_reg;
    logic        tick;
    assign tick = (tmr_reg == 32'(TICK_COUNT - 1));
    always_ff @(posedge i_clk)
    begin
        if (i_rst || tick) tmr_reg <= 32'h0;
        else               tmr_reg <= tmr_reg + 32'h1;
    end

    // ========================================================
    // scroll window
    logic [6:0] off_reg;
    logic       scroll_on;
    assign scroll_on = eff_len > 7'(VIS_CHRS);
    // step forward; wrap from last window; restart on length write or clear
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !scroll_on ||
            (wr_acc && (i_address == OFS_LEN || i_address == OFS_CLEAR)))
            off_reg <= 7'h00;
        else if (tick)
            off_reg <= (off_reg >= eff_len - 7'(VIS_CHRS)) ? 7'h00
                     : off_reg + 7'h01;
    end

    // ========================================================
    // flash phase and fault rotation
    logic       flash_reg;
    logic [5:0] rr_reg;
    logic       any_fault;
    assign any_fault = |faults;

    // next set fault after cur, wrapping; cur if it is the only one
    function automatic logic [5:0] next_fault(
        input logic [N_FAULT-1:0] v, input logic [5:0] cur);
        logic [5:0] r;
        logic       found;
        int         j;
        r = cur;
        found = 1'b0;
        for (int k = 1; k <= N_FAULT; k++)
        begin
            j = (int'(cur) + k) % N_FAULT;
            if (!found && v[j])
            begin
                r = 6'(j);
                found = 1'b1;
            end
        end
        return r;
    endfunction

    always_ff @(posedge i_clk)
    begin
        if (i_rst)     flash_reg <= 1'b0;
        else if (tick) flash_reg <= ~flash_reg;
    end
    // advance once per full flash period, or when fault clears
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !any_fault) rr_reg <= 6'h00;
        else if (!faults[rr_reg] || (tick && flash_reg))
            rr_reg <= next_fault(faults, rr_reg);
    end

    // ========================================================
    // message selection
    fpd_kind_t  fk;
    logic [3:0] fa;
    always_comb
    begin
        fk = MK_FILTER;
        fa = 4'h0;
        if (rr_reg < 6'(F_UV))
        begin fk = MK_RAIL_OV; fa = 4'(rr_reg - 6'(F_OV) + 6'h01); end
        else if (rr_reg < 6'(F_FAN))
        begin fk = MK_RAIL_UV; fa = 4'(rr_reg - 6'(F_UV) + 6'h01); end
        else if (rr_reg < 6'(F_AMB))
        begin fk = MK_FAN; fa = 4'(rr_reg - 6'(F_FAN) + 6'h01); end
        else if (rr_reg < 6'(F_SLOT)) fk = MK_AMBIENT;
        else if (rr_reg < 6'(F_ACK))
        begin fk = MK_SLOT; fa = 4'(rr_reg - 6'(F_SLOT) + 6'h01); end
        else if (rr_reg < 6'(F_BERR))
        begin fk = MK_ACK_LINE; fa = 4'(rr_reg - 6'(F_ACK) + 6'h01); end
        else if (rr_reg == 6'(F_BERR)) fk = MK_BUS_ERROR;
        else if (rr_reg == 6'(F_SYSF)) fk = MK_SYSFAIL;
        else if (rr_reg == 6'(F_ACF))  fk = MK_ACFAIL;
        else if (rr_reg == 6'(F_SESS)) fk = MK_SESSION;
        else if (rr_reg == 6'(F_TOT))  fk = MK_TOTAL;
    end

    // priority; off hides all; empty text is blank
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_msg_kind <= MK_OFF;
            o_msg_arg  <= 4'h0;
            o_blank    <= 1'b0;
        end
        else
        begin
            o_msg_arg <= 4'h0;
            o_blank   <= 1'b0;
            if (!disp_on_reg) o_msg_kind <= MK_OFF;
            else if (any_fault && faults[rr_reg])
            begin
                o_msg_kind <= fk;
                o_msg_arg  <= fa;
                o_blank    <= flash_reg;
            end
            else if (any_fault) o_msg_kind <= o_msg_kind; // rotating
            else if (defined_reg)
                o_msg_kind <= (len_reg == 7'h00) ? MK_BLANK : MK_TEXT;
            else o_msg_kind <= mains ? MK_SYS_OK : MK_STANDBY;
        end
    end

    // nine visible characters; the clock place is not driven here
    always_ff @(posedge i_clk)
    begin
        if (i_rst) o_text <= {VIS_CHRS{CH_SPACE}};
        else
            for (int i = 0; i < VIS_CHRS; i++)
                o_text[8*i +: 8] <= (off_reg + 7'(i) < eff_len)
                                    ? text_mem[off_reg + 7'(i)] : CH_SPACE;
    end

    // ========================================================
    // text query sequencer
    fpd_qstate_t q_state_reg;
    logic [6:0]  q_idx_reg;
    logic [8:0]  q_out;
    logic        q_in_body;
    assign q_in_body = q_idx_reg < eff_len;
    // reply character: valid bit plus char
    always_comb
    begin
        case (q_state_reg)
            Q_OPEN:  q_out = {1'b1, CH_QUOTE};
            Q_BODY:  q_out = {1'b1, q_in_body ? text_mem[q_idx_reg]
                                              : CH_QUOTE};
            Q_DUP:   q_out = {1'b1, CH_QUOTE};
            default: q_out = 9'h000;
        endcase
    end
    // advance on each accepted read; a write restarts the reply
    always_ff @(posedge i_clk)
    begin
        if (i_rst || (wr_acc && i_address == OFS_QUERY))
        begin
            q_state_reg <= Q_OPEN;
            q_idx_reg   <= 7'h00;
        end
        else if (rd_acc && i_address == OFS_QUERY)
            case (q_state_reg)
                Q_OPEN: q_state_reg <= Q_BODY;
                Q_BODY:
                    if (!q_in_body) q_state_reg <= Q_DONE;
                    else if (text_mem[q_idx_reg] == CH_QUOTE)
                        q_state_reg <= Q_DUP;
                    else q_idx_reg <= q_idx_reg + 7'h01;
                Q_DUP:
                begin
                    q_state_reg <= Q_BODY;
                    q_idx_reg   <= q_idx_reg + 7'h01;
                end
                default: q_state_reg <= Q_DONE;
            endcase
    end

    // ========================================================
    // read data, captured in the wait cycle
    always_ff @(posedge i_clk)
    begin
        if (i_rst) o_readdata <= 32'h0;
        else if (i_read && !ack_reg)
            case (i_address)
                OFS_CTRL:   o_readdata <= {31'h0, disp_on_reg};
                OFS_STATUS: o_readdata <= {11'h0, o_msg_kind, 1'b0,
                                           len_reg, 5'h00, mains,
                                           defined_reg, disp_on_reg};
                OFS_LEN:    o_readdata <= {25'h0, len_reg};
                OFS_QUERY:  o_readdata <= {23'h0, q_out};
                default:    o_readdata <= 32'h0;
            endcase
    end

    // ========================================================
    // checks
    property p_reset_on;
        @(posedge i_clk) $past(i_rst) |-> disp_on_reg;
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("display not on after reset");

    property p_off_hides;
        @(posedge i_clk) disable iff (i_rst)
        !disp_on_reg |=> o_msg_kind == MK_OFF;
    endproperty
    a_off_hides: assert property (p_off_hides)
        else $error("message shown while display off");

    property p_state_read;
        @(posedge i_clk) disable iff (i_rst)
        (rd_acc && i_address == OFS_CTRL) |->
            o_readdata == {31'h0, disp_on_reg};
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("display state read wrong");

    property p_len_store;
        @(posedge i_clk) disable iff (i_rst)
        (wr_acc && i_address == OFS_LEN && i_writedata <= 32'(TEXT_MAX))
            |=> defined_reg && len_reg == $past(i_writedata[6:0]);
    endproperty
    a_len_store: assert property (p_len_store)
        else $error("text length not stored");

    property p_scroll_step;
        @(posedge i_clk) disable iff (i_rst)
        (tick && scroll_on && off_reg < eff_len - 7'(VIS_CHRS) && !acc)
            |=> off_reg == $past(off_reg) + 7'h01;
    endproperty
    a_scroll_step: assert property (p_scroll_step)
        else $error("scroll did not step");

    property p_scroll_wrap;
        @(posedge i_clk) disable iff (i_rst)
        (tick && scroll_on && off_reg == eff_len - 7'(VIS_CHRS))
            |=> off_reg == 7'h00;
    endproperty
    a_scroll_wrap: assert property (p_scroll_wrap)
        else $error("scroll did not wrap");

    property p_empty_blank;
        @(posedge i_clk) disable iff (i_rst)
        (disp_on_reg && !any_fault && defined_reg && len_reg == 7'h00)
            |=> o_msg_kind == MK_BLANK;
    endproperty
    a_empty_blank: assert property (p_empty_blank)
        else $error("empty text not blank");

    property p_clear;
        @(posedge i_clk) disable iff (i_rst)
        (wr_acc && i_address == OFS_CLEAR) |=> !defined_reg;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear left text defined");

    property p_idle;
        @(posedge i_clk) disable iff (i_rst)
        (disp_on_reg && !any_fault && !defined_reg) |=>
            o_msg_kind == ($past(mains) ? MK_SYS_OK : MK_STANDBY);
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle message wrong");

    property p_tick_gap;
        @(posedge i_clk) disable iff (i_rst)
        tick |=> !tick [*2];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("timer ticks too close");

    c_scroll_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
        tick && scroll_on && off_reg == eff_len - 7'(VIS_CHRS));
    c_fault_rot: cover property (@(posedge i_clk) disable iff (i_rst)
        tick && flash_reg && $countones(faults) > 1);
    c_quote_dup: cover property (@(posedge i_clk) disable iff (i_rst)
        rd_acc && i_address == OFS_QUERY && q_state_reg == Q_DUP);
endmodule // fpd_display

// *** tb/fpd_panel_model.sv ***
// panel model: the ten-place character display fed by the controller
// assumes kind, blank and text come registered on the system clock
`timescale 1ns/1ns
module fpd_panel_model
    import fpd_pkg::*;
(
    // clock
    input  wire logic                   i_clk,
    // message from the controller
    input  wire fpd_kind_t              i_msg_kind,
    input  wire logic                   i_blank,
    input  wire logic [8*VIS_CHRS-1:0]  i_text,
    // what a viewer sees
    output logic                        o_lit,
    output logic [8*PANEL_CHRS-1:0]     o_row,
    output logic [7:0]                  o_flash_cnt
);
    // glyph value is arbitrary, the real clock symbol lives in the rom
    localparam logic [7:0] CLK_GLYPH = 8'h2A;
    logic       blank_reg = 1'b0;
    logic [7:0] cnt_reg   = 8'h00;
    // ==========================================================
    // visible row
    // dark when off
    assign o_lit = !(i_msg_kind inside {MK_OFF, MK_BLANK}) && !i_blank;
    assign o_row = {CLK_GLYPH, o_lit ? i_text : {VIS_CHRS{CH_SPACE}}};
    // ==========================================================
    // flash edges, counted so the bench can see blinking at all
    // flashing fault messages
    always_ff @(posedge i_clk)
    begin
        blank_reg <= i_blank;
        if (i_blank !== blank_reg)
            cnt_reg <= cnt_reg + 8'h01;
    end
    assign o_flash_cnt = cnt_reg;
endmodule // fpd_panel_model

// *** tb/testbench.sv ***
// self-checking bench for the front panel message display
// assumes fpd_pkg, fpd_display and the panel model are compiled first
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import fpd_pkg::*;
    // short tick keeps scroll and flash within a short run
    localparam int TK = 8;
    logic                   i_clk = 1'b0;
    logic                   i_rst = 1'b1;
    logic [7:0]             i_address = 8'h00;
    logic                   i_read = 1'b0;
    logic                   i_write = 1'b0;
    logic [31:0]            i_writedata = 32'h0000_0000;
    logic                   i_mains_on = 1'b0;
    logic [N_FAULT-1:0]     fv = '0;
    logic [31:0]            o_readdata;
    logic                   o_waitrequest;
    fpd_kind_t              o_msg_kind;
    logic [3:0]             o_msg_arg;
    logic                   o_blank;
    logic [8*VIS_CHRS-1:0]  o_text;
    logic                   lit;
    logic [7:0]             flashes;
    logic [7:0]             snap;
    logic [1:0]             seen;
    logic [31:0]            rd;
    logic [8:0]             exp_code;
    int                     n_fail = 0;
    int                     n_tests = 0;
    int                     cnt;
    logic [7:0]             qry [7] = '{8'h22, 8'h41, 8'h42, 8'h22, 8'h22,
                                        8'h43, 8'h22};
    always #5 i_clk = ~i_clk;
    fpd_display #(.TICK_COUNT(TK)) uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_mains_on(i_mains_on), .i_rail_ov(fv[F_OV+:N_RAIL]),
        .i_rail_uv(fv[F_UV+:N_RAIL]), .i_fan_fault(fv[F_FAN+:N_FAN]),
        .i_ambient_heat_fault(fv[F_AMB]), .i_slot_fault(fv[F_SLOT+:N_SLOT]),
        .i_ack_line_count_fault(fv[F_ACK+:N_ACK]),
        .i_bus_error_count_fault(fv[F_BERR]), .i_sysfail(fv[F_SYSF]),
        .i_acfail(fv[F_ACF]), .i_session_uptime_fault(fv[F_SESS]),
        .i_total_uptime_fault(fv[F_TOT]), .i_filter_fault(fv[F_FILT]),
        .o_msg_kind(o_msg_kind), .o_msg_arg(o_msg_arg), .o_blank(o_blank),
        .o_text(o_text));
    fpd_panel_model panel (
        .i_clk(i_clk), .i_msg_kind(o_msg_kind), .i_blank(o_blank),
        .i_text(o_text), .o_lit(lit), .o_row(), .o_flash_cnt(flashes));
    // ==========================================================
    // verdict, the single place where the run ends
    task automatic report_and_stop;
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one avalon access; request held until waitrequest samples low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge i_clk);
        i_address   <= a;
        i_writedata <= d;
        i_write     <= wr;
        i_read      <= !wr;
        for (i = 0; i < 20; i++)
        begin
            @(posedge i_clk);
            if (o_waitrequest === 1'b0)
                break;
        end
        rd = o_readdata;
        i_write <= 1'b0;
        i_read  <= 1'b0;
        if (i == 20)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask
    // bounded wait for a message, then compare kind and argument
    task automatic wait_kind(input fpd_kind_t k, input logic [3:0] a);
        int i;
        for (i = 0; i < 8*TK; i++)
        begin
            @(posedge i_clk);
            #1;
            if (o_msg_kind === k && o_msg_arg === a)
                break;
        end
        `CHK("msg", {k, a}, {o_msg_kind, o_msg_arg})
        if (i == 8*TK)
            report_and_stop();
    endtask
    // bounded wait for a text window; cnt returns cycles spent
    task automatic wait_text(input logic [8*VIS_CHRS-1:0] e);
        for (cnt = 1; cnt <= 3*TK; cnt++)
        begin
            @(posedge i_clk);
            #1;
            if (o_text === e)
                break;
        end
        `CHK("text", e, o_text)
        if (cnt > 3*TK)
            report_and_stop();
    endtask
    task automatic drive(input logic m, input logic [N_FAULT-1:0] v);
        @(posedge i_clk);
        i_mains_on <= m;
        fv         <= v;
    endtask
    // window of the digit string starting at off
    function automatic logic [8*VIS_CHRS-1:0] win(input int off);
        for (int j = 0; j < VIS_CHRS; j++)
            win[8*j+:8] = (off + j < 11) ? 8'(8'h30 + off + j) : CH_SPACE;
    endfunction
    function automatic logic [8:0] code(input int f);
        if (f < F_UV) return {MK_RAIL_OV, 4'(f - F_OV + 1)};
        if (f < F_FAN) return {MK_RAIL_UV, 4'(f - F_UV + 1)};
        if (f < F_AMB) return {MK_FAN, 4'(f - F_FAN + 1)};
        if (f < F_SLOT) return {MK_AMBIENT, 4'h0};
        if (f < F_ACK) return {MK_SLOT, 4'(f - F_SLOT + 1)};
        if (f < F_BERR) return {MK_ACK_LINE, 4'(f - F_ACK + 1)};
        return {5'(int'(MK_BUS_ERROR) + f - F_BERR), 4'h0};
    endfunction
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl", 1'b1, rd[0])
        wait_kind(MK_STANDBY, 4'h0);
        drive(1'b1, '0);
        wait_kind(MK_SYS_OK, 4'h0);
        bus(1'b1, OFS_CTRL, 32'h0);
        wait_kind(MK_OFF, 4'h0);
        `CHK("lit", 1'b0, lit)
        bus(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl", 1'b0, rd[0])
        // text with an embedded quote, loaded while dark
        // host strips the quote delimiters; only the body is written
        for (int i = 0; i < 4; i++)
            bus(1'b1, OFS_CHAR, (32'(i) << 8) | 32'(qry[i + 1 + (i > 2)]));
        bus(1'b1, OFS_LEN, 32'd4);
        wait_kind(MK_OFF, 4'h0);
        bus(1'b1, OFS_CTRL, 32'h1);
        wait_kind(MK_TEXT, 4'h0);
        wait_text({{5{CH_SPACE}}, 32'h4322_4241});
        bus(1'b1, OFS_QUERY, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, OFS_QUERY, 32'h0);
            `CHK("reply", {1'b1, qry[i]}, rd[8:0])
        end
        bus(1'b0, OFS_QUERY, 32'h0);
        `CHK("reply end", 1'b0, rd[8])
        // faults override text, flash and rotate
        drive(1'b1, N_FAULT'(1) << (F_OV + 2));
        wait_kind(MK_RAIL_OV, 4'h3);
        snap = flashes;
        repeat (4*TK) @(posedge i_clk);
        `CHK("flash", 1'b1, (flashes - snap) >= 8'd2)
        drive(1'b1, (N_FAULT'(1) << (F_OV + 2)) | (N_FAULT'(1) << F_SESS));
        seen = 2'b00;
        repeat (8*TK)
        begin
            @(posedge i_clk);
            #1;
            seen[0] = seen[0] | (o_msg_kind === MK_RAIL_OV);
            seen[1] = seen[1] | (o_msg_kind === MK_SESSION);
        end
        `CHK("rotation", 2'b11, seen)
        bus(1'b1, OFS_CTRL, 32'h0);
        wait_kind(MK_OFF, 4'h0);
        bus(1'b1, OFS_CTRL, 32'h1);
        drive(1'b1, '0);
        // scroll of an eleven-character string, then wrap
        for (int i = 0; i < 11; i++)
            bus(1'b1, OFS_CHAR, (32'(i) << 8) | 32'(8'h30 + i));
        bus(1'b1, OFS_LEN, 32'd11);
        wait_text(win(0));
        wait_text(win(1));
        wait_text(win(2));
        `CHK("step", TK, cnt)
        wait_text(win(0));
        // length limits, then empty text under every fault
        bus(1'b1, OFS_LEN, 32'd80);
        bus(1'b1, OFS_LEN, 32'd81);
        bus(1'b0, OFS_LEN, 32'h0);
        `CHK("len", 8'd80, rd[7:0])
        bus(1'b1, OFS_LEN, 32'd0);
        wait_kind(MK_BLANK, 4'h0);
        // status: kind, zero length, mains, defined and on bits
        bus(1'b0, OFS_STATUS, 32'h0);
        `CHK("status", {MK_BLANK, 16'h0007}, rd[20:0])
        for (int f = 0; f < N_FAULT; f++)
        begin
            drive(1'b1, N_FAULT'(1) << f);
            exp_code = code(f);
            wait_kind(fpd_kind_t'(exp_code[8:4]), exp_code[3:0]);
            drive(1'b1, '0);
            wait_kind(MK_BLANK, 4'h0);
        end
        bus(1'b1, OFS_CLEAR, 32'h0);
        wait_kind(MK_SYS_OK, 4'h0);
        // undefined text replies an empty quoted string, then nothing
        bus(1'b1, OFS_QUERY, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b0, OFS_QUERY, 32'h0);
            `CHK("empty reply", (i < 2) ? {1'b1, CH_QUOTE} : 9'h000, rd[8:0])
        end
        report_and_stop();
    end
endmodule // testbench
